// ### inc/pager_cfg_defines.svh
// Constants for the packet interpreter: ids, field positions, reset values, timing
`ifndef PAGER_CFG_DEFINES_SVH
`define PAGER_CFG_DEFINES_SVH
`define PKT_BITS 6'd32
`define PKT_ID_CHECKSUM 8'h00
`define PKT_ID_CONFIG 8'h01
`define PKT_ID_CONTROL 8'h02
`define PKT_ID_SPECIAL_LO 8'h1C
`define PKT_ID_SPECIAL_HI 8'h1F
`define CFG_RESET 24'h000000
`define CFG_FRAC_DIS 22
`define CFG_DEMOD_EN 18
`define CFG_OSC_TOL_HI 17
`define CFG_OSC_TOL_LO 16
`define CFG_PARTIAL 10
`define CFG_POL_HIGH 9
`define CFG_POL_LOW 8
`define CFG_SYNC_REP 7
`define CFG_MAX_OFF 6
`define CFG_CLK_DIS 5
`define CFG_MIN_TMR 4
`define CFG_BAT_POL 3
`define CFG_INTERMIT 2
`define CTL_ON 0
`define CTL_MTC 4
`define ST_ID_STATUS 8'h7F
`define ST_ID_PART 8'hFF
`define ST_MINUTE_BIT 0
`define ST_SYNC_BIT 1
`define ST_BAT_BIT 2
`define CLK_GUARD_TICKS 4'h4
`define FRAC_NUM 5'h19
`define FRAC_DEN 5'h06
`endif

// ### inc/pager_cfg_pkg.sv
// Types shared by the packet interpreter
package pager_cfg_pkg;
    typedef enum logic [1:0] {
        GATE_DISABLED = 2'b01,
        GATE_ENABLED = 2'b10
    } gate_state_t;
    typedef enum logic [1:0] {
        TOL_300PPM = 2'b00,
        TOL_150PPM = 2'b01,
        TOL_75PPM = 2'b10,
        TOL_0PPM = 2'b11
    } osc_tol_t;
endpackage

// ### hdl/clock_out_gen.sv
// Receiver clock output generator; glitch-free gating only for intermittent mode, not clock disable
`timescale 1ns/1ps
`include "pager_cfg_defines.svh"
module clock_out_gen
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Crystal tick and settings
    input wire logic i_xtal_tick,
    input wire logic i_demod_enable,
    input wire logic i_frac_disable,
    input wire logic i_clock_disable,
    input wire logic i_intermittent,
    input wire logic i_receiver_on,
    // Clock out
    output logic o_clk
);
    logic [4:0] acc;
    logic [4:0] next_acc;
    logic clk_q;
    logic next_clk_q;
    logic gate;
    logic next_gate;
    logic [3:0] guard;
    logic [3:0] next_guard;
    logic half_tick;
    logic [4:0] inc;
    logic [4:0] lim;
    logic [5:0] sum;
    logic want;

    // ------------------------------------------------------------
    // Divider: half period = 2 ticks (/4), 1 tick (/2) or 25/12 ticks
    // ------------------------------------------------------------
    always_comb
    begin
        if (!i_demod_enable)
        begin
            inc = 5'h01;
            lim = 5'h01;
        end
        else if (i_frac_disable)
        begin
            inc = 5'h01;
            lim = 5'h02;
        end
        else
        begin
            inc = 5'(`FRAC_DEN * 2);
            lim = `FRAC_NUM;
        end
        half_tick = 1'b0;
        next_acc = acc;
        // One spare bit: accumulator plus step can pass 31 in fractional mode
        sum = {1'b0, acc} + {1'b0, inc};
        if (i_xtal_tick)
        begin
            if (sum >= {1'b0, lim})
            begin
                half_tick = 1'b1;
                next_acc = 5'(sum - {1'b0, lim});
            end
            else
            begin
                next_acc = sum[4:0];
            end
        end
        next_clk_q = half_tick ? ~clk_q : clk_q;
        // Guard window keeps the clock running 4 cycles after receiver activity ends
        next_guard = guard;
        if (i_receiver_on)
        begin
            next_guard = `CLK_GUARD_TICKS;
        end
        else if (half_tick && clk_q && guard != 4'h0)
        begin
            next_guard = 4'(guard - 4'h1);
        end
        want = !i_clock_disable && (!i_intermittent || i_receiver_on || guard != 4'h0);
        // Intermittent gate only changes while clock is low, unless clock disable is set: no runt pulses
        next_gate = gate;
        if (!i_intermittent || i_clock_disable)
        begin
            next_gate = want;
        end
        else if (!clk_q)
        begin
            next_gate = want;
        end
    end

    // Divider keeps running through reset so the output keeps toggling in reset
    always_ff @(posedge i_ref_clk)
    begin
        acc <= next_acc;
        clk_q <= next_clk_q;
        if (i_sys_rst)
        begin
            gate <= 1'b1;
            guard <= 4'h0;
            o_clk <= next_clk_q;
        end
        else
        begin
            gate <= next_gate;
            guard <= next_guard;
            o_clk <= next_gate & next_clk_q;
        end
    end
endmodule

// ### hdl/pager_packet_interp.sv
// Host packet interpreter: checksum gate and configuration register
`timescale 1ns/1ps
`include "pager_cfg_defines.svh"
module pager_packet_interp
#(
    parameter logic [23:0] PART_ID = 24'h5A3C96, // Arbitrary identity value
    parameter int unsigned MINUTE_TICKS = 32'd9600000, // Crystal ticks per minute
    parameter int unsigned SEARCH_MIN_TICKS = 32'd9600000 // Crystal ticks per search minute
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Serial link, synchronous samples
    input wire logic i_ss_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    // Crystal tick and receiver side
    input wire logic i_xtal_tick,
    input wire logic i_symbol_input_high,
    input wire logic i_symbol_input_low,
    input wire logic i_battery_detect_input,
    input wire logic i_sync_update_flag,
    input wire logic i_receiver_on,
    input wire logic i_async_search_zero,
    input wire logic i_search_start,
    input wire logic i_no_match_possible,
    // Outbound gating
    input wire logic i_report_taken,
    output logic o_output_enabled,
    output logic o_part_id_request,
    output logic o_status_request,
    output logic [7:0] o_status_flags,
    // Configuration and decoded views
    output logic [23:0] o_decoder_configuration,
    output logic [23:0] o_checksum,
    output logic o_demodulator_enable,
    output logic [1:0] o_oscillator_tolerance,
    output logic o_symbol_high,
    output logic o_symbol_low,
    output logic o_receiver_early_off,
    output logic o_search_timeout,
    output logic o_receiver_clock_out
);
    localparam int unsigned CNT_W = $clog2(MINUTE_TICKS * 4 + 1);

    // Search counter shares the minute counter's width
    if (MINUTE_TICKS < 1 || SEARCH_MIN_TICKS < 1 || SEARCH_MIN_TICKS > MINUTE_TICKS
        || CNT_W > 32)
    begin : g_bad_ticks
        $error("Tick counts out of range");
    end

    logic ss_q;
    logic sck_q;
    logic [31:0] shreg;
    logic [31:0] next_shreg;
    logic [5:0] bitcnt;
    logic [5:0] next_bitcnt;
    logic pkt_done;
    pager_cfg_pkg::gate_state_t gate;
    pager_cfg_pkg::gate_state_t next_gate;
    logic [23:0] csum;
    logic [23:0] next_csum;
    logic [23:0] cfg;
    logic [23:0] next_cfg;
    logic [7:0] pkt_id;
    logic [23:0] pkt_data;
    logic is_special;
    logic ctl_on;
    logic next_ctl_on;
    logic mtc_pulse;
    logic [CNT_W-1:0] min_cnt;
    logic [CNT_W-1:0] next_min_cnt;
    logic [CNT_W-1:0] srch_cnt;
    logic [CNT_W-1:0] next_srch_cnt;
    logic minute_ev;
    logic [7:0] flags;
    logic [7:0] next_flags;
    logic bat_flag;
    logic next_bat_flag;
    logic bat_reported;
    logic next_bat_reported;
    logic search_to;
    logic next_search_to;
    logic [CNT_W-1:0] search_lim;

    // ------------------------------------------------------------
    // Serial receive
    // ------------------------------------------------------------
    always_comb
    begin
        next_shreg = shreg;
        next_bitcnt = bitcnt;
        pkt_done = 1'b0;
        if (i_ss_n)
        begin
            next_bitcnt = 6'h00;
        end
        else if (ss_q)
        begin
            next_bitcnt = 6'h00;
        end
        else if (i_sck && !sck_q)
        begin
            next_shreg = {shreg[30:0], i_mosi};
            if (bitcnt == `PKT_BITS - 6'h01)
            begin
                pkt_done = 1'b1;
                next_bitcnt = 6'h00; // Back-to-back packets without deselect
            end
            else
            begin
                next_bitcnt = 6'(bitcnt + 6'h01);
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ss_q <= 1'b1;
            sck_q <= 1'b0;
            shreg <= 32'h0000_0000;
            bitcnt <= 6'h00;
        end
        else
        begin
            ss_q <= i_ss_n;
            sck_q <= i_sck;
            shreg <= next_shreg;
            bitcnt <= next_bitcnt;
        end
    end

    // ------------------------------------------------------------
    // Checksum gate and configuration
    // ------------------------------------------------------------
    assign pkt_id = next_shreg[31:24];
    assign pkt_data = next_shreg[23:0];
    assign is_special = pkt_id >= `PKT_ID_SPECIAL_LO && pkt_id <= `PKT_ID_SPECIAL_HI;

    always_comb
    begin
        next_gate = gate;
        next_csum = csum;
        next_cfg = cfg;
        next_ctl_on = ctl_on;
        mtc_pulse = 1'b0;
        if (pkt_done)
        begin
            if (pkt_id == `PKT_ID_CHECKSUM)
            begin
                if (gate == pager_cfg_pkg::GATE_DISABLED && pkt_data == csum)
                begin
                    next_gate = pager_cfg_pkg::GATE_ENABLED;
                end
            end
            else if (!is_special)
            begin
                next_csum = csum ^ pkt_data;
                next_gate = pager_cfg_pkg::GATE_DISABLED;
                if (pkt_id == `PKT_ID_CONFIG)
                begin
                    next_cfg = pkt_data;
                end
                if (pkt_id == `PKT_ID_CONTROL)
                begin
                    next_ctl_on = pkt_data[`CTL_ON];
                    mtc_pulse = pkt_data[`CTL_MTC];
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            gate <= pager_cfg_pkg::GATE_DISABLED;
            csum <= PART_ID;
            cfg <= `CFG_RESET;
            ctl_on <= 1'b0;
        end
        else
        begin
            gate <= next_gate;
            csum <= next_csum;
            cfg <= next_cfg;
            ctl_on <= next_ctl_on;
        end
    end

    // ------------------------------------------------------------
    // Timers and status flags
    // ------------------------------------------------------------
    assign search_lim = cfg[`CFG_MAX_OFF] ? CNT_W'(SEARCH_MIN_TICKS)
                                         : CNT_W'(SEARCH_MIN_TICKS * 4);

    always_comb
    begin
        next_min_cnt = min_cnt;
        minute_ev = 1'b0;
        if (!cfg[`CFG_MIN_TMR] || (pkt_done && pkt_id == `PKT_ID_CONFIG
            && pkt_data[`CFG_MIN_TMR] && !cfg[`CFG_MIN_TMR]) || mtc_pulse)
        begin
            next_min_cnt = '0;
        end
        else if (i_xtal_tick)
        begin
            if (min_cnt == CNT_W'(MINUTE_TICKS - 1))
            begin
                next_min_cnt = '0;
                minute_ev = 1'b1;
            end
            else
            begin
                next_min_cnt = CNT_W'(min_cnt + 1'b1);
            end
        end
        next_srch_cnt = srch_cnt;
        next_search_to = 1'b0;
        if (i_search_start || !i_async_search_zero)
        begin
            next_srch_cnt = '0;
        end
        else if (i_xtal_tick)
        begin
            if (srch_cnt >= CNT_W'(search_lim - 1'b1))
            begin
                next_srch_cnt = '0;
                next_search_to = 1'b1;
            end
            else
            begin
                next_srch_cnt = CNT_W'(srch_cnt + 1'b1);
            end
        end
        next_bat_flag = bat_flag;
        next_bat_reported = bat_reported;
        if (next_ctl_on && !ctl_on)
        begin
            next_bat_flag = ~cfg[`CFG_BAT_POL];
            next_bat_reported = 1'b0;
        end
        else
        begin
            next_bat_flag = i_battery_detect_input ^ ~cfg[`CFG_BAT_POL];
        end
        // Set wins over the clear by the host taking the report
        next_flags = i_report_taken ? 8'h00 : flags;
        if (minute_ev)
        begin
            next_flags[`ST_MINUTE_BIT] = 1'b1;
        end
        if (i_sync_update_flag && cfg[`CFG_SYNC_REP])
        begin
            next_flags[`ST_SYNC_BIT] = 1'b1;
        end
        if (ctl_on && !bat_reported && next_bat_flag == cfg[`CFG_BAT_POL])
        begin
            next_flags[`ST_BAT_BIT] = 1'b1;
            next_bat_reported = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            min_cnt <= '0;
            srch_cnt <= '0;
            flags <= 8'h00;
            bat_flag <= 1'b1;
            bat_reported <= 1'b0;
            search_to <= 1'b0;
        end
        else
        begin
            min_cnt <= next_min_cnt;
            srch_cnt <= next_srch_cnt;
            flags <= next_flags;
            bat_flag <= next_bat_flag;
            bat_reported <= next_bat_reported;
            search_to <= next_search_to;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_output_enabled <= 1'b0;
            o_part_id_request <= 1'b0;
            o_status_request <= 1'b0;
            o_status_flags <= 8'h00;
            o_decoder_configuration <= `CFG_RESET;
            o_checksum <= PART_ID;
            o_demodulator_enable <= 1'b0;
            o_oscillator_tolerance <= pager_cfg_pkg::TOL_300PPM;
            o_symbol_high <= 1'b0;
            o_symbol_low <= 1'b0;
            o_receiver_early_off <= 1'b0;
            o_search_timeout <= 1'b0;
        end
        else
        begin
            o_output_enabled <= next_gate == pager_cfg_pkg::GATE_ENABLED;
            o_part_id_request <= next_gate == pager_cfg_pkg::GATE_DISABLED;
            o_status_request <= next_gate == pager_cfg_pkg::GATE_ENABLED
                                && next_flags != 8'h00;
            o_status_flags <= next_flags;
            o_decoder_configuration <= next_cfg;
            o_checksum <= next_csum;
            o_demodulator_enable <= next_cfg[`CFG_DEMOD_EN];
            o_oscillator_tolerance <= next_cfg[`CFG_OSC_TOL_HI:`CFG_OSC_TOL_LO];
            o_symbol_high <= i_symbol_input_high ^ next_cfg[`CFG_POL_HIGH];
            o_symbol_low <= i_symbol_input_low ^ next_cfg[`CFG_POL_LOW];
            o_receiver_early_off <= next_cfg[`CFG_PARTIAL] && i_no_match_possible;
            o_search_timeout <= search_to;
        end
    end

    clock_out_gen u_clock_out_gen
    (
        .i_ref_clk(i_ref_clk),
        .i_sys_rst(i_sys_rst),
        .i_xtal_tick(i_xtal_tick),
        .i_demod_enable(cfg[`CFG_DEMOD_EN]),
        .i_frac_disable(cfg[`CFG_FRAC_DIS]),
        .i_clock_disable(cfg[`CFG_CLK_DIS]),
        .i_intermittent(cfg[`CFG_INTERMIT]),
        .i_receiver_on(i_receiver_on),
        .o_clk(o_receiver_clock_out)
    );
endmodule

// ### tb/pager_packet_interp_props.sv
// Checker for the packet interpreter's gate and configuration outputs
`timescale 1ns/1ps
module pager_packet_interp_props
#(
    parameter logic [23:0] PART_ID = 24'h5A3C96 // Arbitrary identity value
)
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // Serial link and symbol input
    input wire logic i_ss_n,
    input wire logic i_sck,
    input wire logic i_mosi,
    input wire logic i_symbol_input_high,
    // Watched outputs
    input wire logic o_output_enabled,
    input wire logic o_part_id_request,
    input wire logic [23:0] o_decoder_configuration,
    input wire logic [23:0] o_checksum,
    input wire logic o_symbol_high,
    input wire logic o_receiver_clock_out
);
    logic sck_q;
    logic ss_q;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [30:0] sh;
    logic take;
    logic done;
    logic [31:0] pkt;
    logic [7:0] id;
    logic [23:0] data;
    // --------------------------------
    // Packet framing
    // --------------------------------
    always_comb
    begin
        take = i_sck && !sck_q && !i_ss_n && !ss_q;
        done = take && cnt == 5'h1F;
        pkt = {sh, i_mosi};
        id = pkt[31:24];
        data = pkt[23:0];
        next_cnt = i_ss_n ? 5'h00 : (take ? cnt + 5'h01 : cnt);
    end
    always_ff @(posedge i_ref_clk)
    begin
        sck_q <= i_sck;
        ss_q <= i_ss_n;
        cnt <= i_sys_rst ? 5'h00 : next_cnt;
        sh <= take ? pkt[30:0] : sh;
    end
    // --------------------------------
    // Properties
    // --------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_data_pkt;
        done && id != 8'h00 && !(id >= 8'h1C && id <= 8'h1F);
    endsequence
    sequence s_check_pkt;
        done && id == 8'h00;
    endsequence
    sequence s_sym_steady;
        ($stable(i_symbol_input_high) && $stable(o_decoder_configuration))[*3];
    endsequence
    sequence s_clk_off;
        (o_decoder_configuration[5] && $stable(o_decoder_configuration))[*8];
    endsequence
    property p_reset_load;
        $fell(i_sys_rst) |-> o_checksum == PART_ID && !o_output_enabled
            && o_decoder_configuration == 24'h000000;
    endproperty
    property p_part_req;
        !$past(i_sys_rst) |-> o_part_id_request == !o_output_enabled;
    endproperty
    property p_xor;
        s_data_pkt |=> !o_output_enabled && o_checksum == ($past(o_checksum) ^ $past(data));
    endproperty
    property p_enable;
        s_check_pkt ##0 (!o_output_enabled && data == o_checksum) |=> o_output_enabled;
    endproperty
    property p_mismatch;
        s_check_pkt ##0 (!o_output_enabled && data != o_checksum)
            |=> !o_output_enabled && $stable(o_checksum);
    endproperty
    property p_ignore;
        s_check_pkt ##0 o_output_enabled |=> o_output_enabled && $stable(o_checksum);
    endproperty
    property p_special;
        done && id >= 8'h1C && id <= 8'h1F |=> $stable(o_checksum) && $stable(o_output_enabled);
    endproperty
    property p_cfg_write;
        done && id == 8'h01 |=> o_decoder_configuration == $past(data);
    endproperty
    property p_cfg_hold;
        !(done && id == 8'h01) |=> $stable(o_decoder_configuration);
    endproperty
    property p_symbol;
        s_sym_steady |-> o_symbol_high == (i_symbol_input_high ^ o_decoder_configuration[9]);
    endproperty
    property p_clk_off;
        s_clk_off |-> !o_receiver_clock_out;
    endproperty
    a_reset_load: assert property (p_reset_load)
        else $error("reset state wrong");
    a_part_req: assert property (p_part_req)
        else $error("part id request not opposite of gate");
    a_xor: assert property (p_xor)
        else $error("checksum not folded or gate open");
    a_enable: assert property (p_enable)
        else $error("matching check value did not open gate");
    a_mismatch: assert property (p_mismatch)
        else $error("wrong check value changed state");
    a_ignore: assert property (p_ignore)
        else $error("check packet while open changed state");
    a_special: assert property (p_special)
        else $error("special packet changed state");
    a_cfg_write: assert property (p_cfg_write)
        else $error("configuration not loaded");
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("configuration changed without packet");
    a_symbol: assert property (p_symbol)
        else $error("symbol polarity wrong");
    a_clk_off: assert property (p_clk_off)
        else $error("clock out not held low");
endmodule
bind pager_packet_interp pager_packet_interp_props #(.PART_ID(PART_ID)) props_inst
(
    .i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst),
    .i_ss_n(i_ss_n),
    .i_sck(i_sck),
    .i_mosi(i_mosi),
    .i_symbol_input_high(i_symbol_input_high),
    .o_output_enabled(o_output_enabled),
    .o_part_id_request(o_part_id_request),
    .o_decoder_configuration(o_decoder_configuration),
    .o_checksum(o_checksum),
    .o_symbol_high(o_symbol_high),
    .o_receiver_clock_out(o_receiver_clock_out)
);

// ### tb/host_spi_model.sv
// Host controller model: serial master sending packets
`timescale 1ns/1ps
module host_spi_model
(
    // Clock
    input wire logic i_ref_clk,
    // Serial link
    output logic o_ss_n,
    output logic o_sck,
    output logic o_mosi
);
    int hp = 1;
    initial
    begin
        o_ss_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // Serial clock stands low outside frames; data line shows no stale bit
    task automatic send(input logic [31:0] pkt, input int nbits, input bit keep);
        if (o_ss_n)
        begin
            tick(1);
            o_ss_n = 1'b0;
        end
        for (int i = 31; i > 31 - nbits; i--)
        begin
            tick(1);
            o_mosi = pkt[i];
            tick(hp);
            o_sck = 1'b1;
            tick(hp);
            o_sck = 1'b0;
        end
        tick(1);
        if (!keep)
        begin
            o_ss_n = 1'b1;
            o_mosi = ~o_mosi;
        end
    endtask
endmodule

// ### tb/tb_paging_decoder_checksum_config.sv
// Self-checking bench for the packet interpreter
`timescale 1ns/1ps
module tb_paging_decoder_checksum_config;
    localparam logic [23:0] PID = 24'h3C5A69; // Arbitrary identity value
    typedef struct {logic [23:0] cfg; logic rx; int rises;} row_t;
    row_t rows[7] = '{'{24'h000000, 1'b1, 150}, '{24'h440090, 1'b1, 75},
        '{24'h050540, 1'b1, 72}, '{24'h420220, 1'b1, 0}, '{24'h4703D0, 1'b1, 75},
        '{24'h000004, 1'b0, 0}, '{24'h000004, 1'b1, 150}};
    logic i_ref_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic xtal = 1'b0;
    logic [1:0] sym = 2'h0;
    logic rx_on = 1'b1;
    logic start = 1'b0;
    logic taken = 1'b0;
    logic nomatch = 1'b0;
    logic sync_up = 1'b1;
    logic status_req;
    logic [1:0] exp_fl;
    logic ss_n, sck, mosi, enabled, part_req, early_off, timeout, clk_out, demod, sym_h, sym_l;
    logic [7:0] flags;
    logic [23:0] cfg, csum, exp_sum;
    logic [1:0] tol;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int n, first;
    logic prev;
    initial
    begin
        forever #4 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk)
    begin
        #1;
        cyc++;
        xtal = (cyc % 4 == 0);
    end
    host_spi_model host_spi_model_inst (.i_ref_clk(i_ref_clk), .o_ss_n(ss_n), .o_sck(sck),
        .o_mosi(mosi));
    pager_packet_interp #(.PART_ID(PID), .MINUTE_TICKS(10), .SEARCH_MIN_TICKS(10))
        pager_packet_interp_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .i_ss_n(ss_n), .i_sck(sck), .i_mosi(mosi), .i_xtal_tick(xtal),
        .i_symbol_input_high(sym[1]), .i_symbol_input_low(sym[0]),
        .i_battery_detect_input(1'b1), .i_sync_update_flag(sync_up), .i_receiver_on(rx_on),
        .i_async_search_zero(1'b1), .i_search_start(start), .i_no_match_possible(nomatch),
        .i_report_taken(taken), .o_output_enabled(enabled), .o_part_id_request(part_req),
        .o_status_request(status_req), .o_status_flags(flags), .o_decoder_configuration(cfg),
        .o_checksum(csum), .o_demodulator_enable(demod), .o_oscillator_tolerance(tol),
        .o_symbol_high(sym_h), .o_symbol_low(sym_l), .o_receiver_early_off(early_off),
        .o_search_timeout(timeout), .o_receiver_clock_out(clk_out));
    task automatic tick(input int k);
        repeat (k) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic check_in(input string what, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi)
        begin
            err_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic pkt(input logic [7:0] id, input logic [23:0] d, input bit keep = 1'b0);
        host_spi_model_inst.send({id, d}, 32, keep);
        if (id != 8'h00 && !(id >= 8'h1C && id <= 8'h1F))
            exp_sum = exp_sum ^ d;
        tick(3);
    endtask
    task automatic gate(input logic en, input logic [23:0] sum);
        check("gate", {23'h0, en}, {23'h0, enabled});
        check("part id request", {23'h0, !en}, {23'h0, part_req});
        check("checksum", sum, csum);
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        tick(60000);
        err_count++;
        $display("unexpected watchdog: expected finish, seen hang");
        final_report();
    end
    initial
    begin
        exp_sum = PID;
        tick(10);
        check("config at reset", 24'h000000, cfg);
        i_sys_rst = 1'b0;
        tick(1);
        gate(1'b0, PID);
        $display("test reset done");
        pkt(8'h00, exp_sum ^ 24'h000001);
        gate(1'b0, PID);
        pkt(8'h00, exp_sum);
        gate(1'b1, PID);
        pkt(8'h00, 24'h000000);
        gate(1'b1, PID);
        for (int s = 8'h1C; s <= 8'h1F; s++)
        begin
            pkt(s[7:0], 24'hA5A5A5);
            gate(1'b1, PID);
        end
        pkt(8'h02, 24'h000000, 1'b1);
        gate(1'b0, PID);
        pkt(8'h27, 24'h123456);
        gate(1'b0, exp_sum);
        $display("test gate done");
        foreach (rows[i])
        begin
            rx_on = rows[i].rx;
            sym = i[1:0];
            nomatch = i[1];
            sync_up = !i[2];
            pkt(8'h01, rows[i].cfg);
            pkt(8'h00, exp_sum);
            gate(1'b1, exp_sum);
            taken = 1'b1;
            start = 1'b1;
            tick(1);
            taken = 1'b0;
            start = 1'b0;
            n = 0;
            first = -1;
            for (int c = 0; c < 1200; c++)
            begin
                prev = clk_out;
                tick(1);
                n += (clk_out && !prev);
                if (timeout && first < 0)
                    first = c;
            end
            check("config", rows[i].cfg, cfg);
            check_in("clock rises", rows[i].rises - 2, rows[i].rises + 2, n);
            check("demod", {23'h0, rows[i].cfg[18]}, {23'h0, demod});
            check("tolerance", {22'h0, rows[i].cfg[17:16]}, {22'h0, tol});
            check("symbols", {22'h0, sym ^ rows[i].cfg[9:8]}, {22'h0, sym_h, sym_l});
            check("early off", {23'h0, rows[i].cfg[10] && nomatch}, {23'h0, early_off});
            exp_fl = {rows[i].cfg[7] && sync_up, rows[i].cfg[4]};
            check("flags", {22'h0, exp_fl}, {22'h0, flags[1:0]});
            check("status request", {23'h0, |exp_fl}, {23'h0, status_req});
            n = rows[i].cfg[6] ? 40 : 160;
            check_in("search time", n - 8, n + 8, first);
            $display("test row %0d done", i);
        end
        host_spi_model_inst.send({8'h01, 24'hFFFFFF}, 16, 1'b0);
        tick(2);
        pkt(8'h01, 24'h000010);
        check("config after abort", 24'h000010, cfg);
        gate(1'b0, exp_sum);
        host_spi_model_inst.hp = 3;
        pkt(8'h00, exp_sum);
        gate(1'b1, exp_sum);
        host_spi_model_inst.hp = 1;
        $display("test abort and slow host done");
        i_sys_rst = 1'b1;
        n = 0;
        for (int c = 0; c < 16; c++)
        begin
            prev = clk_out;
            tick(1);
            n += (clk_out && !prev);
        end
        check_in("clock rises in reset", 1, 3, n);
        check("config at reset", 24'h000000, cfg);
        i_sys_rst = 1'b0;
        tick(1);
        gate(1'b0, PID);
        $display("test second reset done");
        final_report();
    end
endmodule
